/* logic/ast_pkg.sv */
`default_nettype none
package ast_pkg;
	// register map, byte offsets on the register port
	localparam logic [7:0] AST_ADDR_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] AST_ADDR_RX_STATUS = 8'h18;
	localparam logic [7:0] AST_ADDR_TX_BUFFER = 8'h19;
	localparam logic [7:0] AST_ADDR_RX_PORT = 8'h1A;
	localparam logic [7:0] AST_ADDR_IRQ_EN = 8'h8C;
	localparam logic [7:0] AST_ADDR_TX_STATUS = 8'h98;
	localparam logic [7:0] AST_ADDR_BAUD_DIV = 8'h99;

	// reset values
	localparam logic [7:0] AST_RST_IRQ_FLAGS = 8'h00;
	localparam logic [7:0] AST_RST_RX_STATUS = 8'h00;
	localparam logic [7:0] AST_RST_TX_BUFFER = 8'h00;
	localparam logic [7:0] AST_RST_IRQ_EN = 8'h00;
	localparam logic [7:0] AST_RST_TX_STATUS = 8'h02;
	localparam logic [7:0] AST_RST_BAUD_DIV = 8'h00;

	// peripheral_irq_flags / peripheral_irq_enables fields
	localparam int AST_BIT_RX_AVAIL = 5;
	localparam int AST_BIT_TX_EMPTY = 4;
	// receive_status_control fields
	localparam int AST_BIT_PORT_EN = 7;
	localparam int AST_BIT_RX_NINE_SEL = 6;
	localparam int AST_BIT_RX_CONT_EN = 4;
	localparam int AST_BIT_RX_FRAME_ERR = 2;
	localparam int AST_BIT_RX_OVERRUN = 1;
	localparam int AST_BIT_RX_NINTH = 0;
	// transmit_status_control fields
	localparam int AST_BIT_CLK_SRC = 7;
	localparam int AST_BIT_TX_NINE_SEL = 6;
	localparam int AST_BIT_TX_EN = 5;
	localparam int AST_BIT_SYNC_SEL = 4;
	localparam int AST_BIT_HIGH_SPEED = 2;
	localparam int AST_BIT_TX_SH_EMPTY = 1;
	localparam int AST_BIT_TX_NINTH = 0;

	// timing: x16 sample clock, x64 mode divides baud ticks by four
	localparam logic [1:0] AST_PRESCALE_LAST = 2'd3;
	localparam logic [3:0] AST_SUB_LAST = 4'd15;
	localparam logic [3:0] AST_SUB_VOTE_A = 4'd6;
	localparam logic [3:0] AST_SUB_VOTE_B = 4'd7;
	localparam logic [3:0] AST_SUB_VOTE_C = 4'd8;
	localparam logic [3:0] AST_LAST_BIT_8 = 4'd7;
	localparam logic [3:0] AST_LAST_BIT_9 = 4'd8;
	localparam logic [1:0] AST_RX_FIFO_DEPTH = 2'd2;

	typedef enum logic [1:0] {AST_IDLE, AST_START, AST_DATA, AST_STOP} ast_frame_state_t;
endpackage
`default_nettype wire

/* logic/ast_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface ast_link_if;
	logic dev_tx;
	logic dev_tx_oe;
	logic rem_tx;
	logic tx_line;

	// undriven transmit line is pulled to the idle level
	assign tx_line = dev_tx_oe ? dev_tx : 1'b1;

	modport dev(output dev_tx, output dev_tx_oe, input rem_tx);
	modport rem(input tx_line, output rem_tx);
endinterface
`default_nettype wire

/* logic/ast_serial_dev.sv */
// Notes on behaviour
// - nrz frame: start, 8/9 bits lsb first, stop
// - one 8-bit baud generator for both directions
// - high speed select picks x16 or x64
// - no parity logic; ninth bit carries it
// - sleep halts all transmit and receive activity
// - software clears sync select, sets port enable
// - shifter loads after stop bit, one cycle
// - buffer empty flag cleared only by write
// - shifter empty status bit, read only, polled
// - transmit enable sets buffer empty flag
// - frame starts with data and shift clock
// - empty shifter takes written byte at once
// - clearing transmit enable aborts, releases pin
// - ninth transmit bit written before data byte
// - receive recovery runs at sixteen times baud
// - reception only while continuous enable set
// - stop bit sampled: push fifo, flag data
// - data available flag read only, auto clears
// - two-entry receive fifo, read twice
// - full fifo at stop: overrun, byte lost
// - overrun blocks pushes until enable toggled
// - stop low sets framing error; travels fifo
// - majority of three samples at 7,8,9
`timescale 1ns/1ps
`default_nettype none
module ast_serial_dev
	import ast_pkg::*;
(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic sleep_in,
	// register port
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic irq_out,
	// serial link
	ast_link_if.dev link
);
	logic [7:0] irq_en_r, baud_div_r, hold_r;
	logic port_en_r, rx_nine_sel_r, rx_cont_en_r;
	logic clk_src_r, tx_nine_sel_r, tx_en_r, sync_sel_r, high_speed_r, tx_ninth_r;
	logic hold_full_r, tx_empty_flag_r;
	logic [7:0] brg_cnt_r;
	logic [1:0] pre_r;
	logic port_on, brg_tick, samp_tick, run;
	logic wr_txbuf, wr_transmit_status_control, tx_active, xfer, bit_tick;

	assign run = !sleep_in;
	assign port_on = port_en_r && !sync_sel_r;
	assign wr_txbuf = reg_wr_in && reg_addr_in == AST_ADDR_TX_BUFFER;
	assign wr_transmit_status_control = reg_wr_in && reg_addr_in == AST_ADDR_TX_STATUS;

	// register writes
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			irq_en_r <= AST_RST_IRQ_EN;
			baud_div_r <= AST_RST_BAUD_DIV;
			{port_en_r, rx_nine_sel_r, rx_cont_en_r} <= 3'b000;
			{clk_src_r, tx_nine_sel_r, tx_en_r, sync_sel_r} <= 4'b0000;
			{high_speed_r, tx_ninth_r} <= 2'b00;
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				AST_ADDR_IRQ_EN: irq_en_r <= reg_wdata_in;
				AST_ADDR_BAUD_DIV: baud_div_r <= reg_wdata_in;
				AST_ADDR_RX_STATUS: begin
					port_en_r <= reg_wdata_in[AST_BIT_PORT_EN];
					rx_nine_sel_r <= reg_wdata_in[AST_BIT_RX_NINE_SEL];
					rx_cont_en_r <= reg_wdata_in[AST_BIT_RX_CONT_EN];
				end
				AST_ADDR_TX_STATUS: begin
					clk_src_r <= reg_wdata_in[AST_BIT_CLK_SRC];
					tx_nine_sel_r <= reg_wdata_in[AST_BIT_TX_NINE_SEL];
					tx_en_r <= reg_wdata_in[AST_BIT_TX_EN];
					sync_sel_r <= reg_wdata_in[AST_BIT_SYNC_SEL];
					high_speed_r <= reg_wdata_in[AST_BIT_HIGH_SPEED];
					tx_ninth_r <= reg_wdata_in[AST_BIT_TX_NINTH];
				end
				default: ;
			endcase
		end
	end

	// baud generator: tick every divisor+1 clocks
	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !port_on) begin
			brg_cnt_r <= 8'h00;
			pre_r <= 2'd0;
		end else if (run) begin
			brg_cnt_r <= (brg_cnt_r == 8'h00) ? baud_div_r : brg_cnt_r - 8'h01;
			if (brg_tick && !high_speed_r)
				pre_r <= pre_r + 2'd1;
		end
	end
	assign brg_tick = port_on && run && brg_cnt_r == 8'h00;
	// both modes reduce to one x16 sample clock
	assign samp_tick = brg_tick && (high_speed_r || pre_r == AST_PRESCALE_LAST);

	// transmitter
	ast_frame_state_t tx_state_r;
	logic tx_loaded_r, tx_line_r, tx_oe_r;
	logic [8:0] tx_sh_r;
	logic [3:0] tx_bits_r, tx_sub_r;
	logic tx_nine_r;

	assign tx_active = port_on && tx_en_r;
	// no transfer in a transmit buffer write cycle, so refill and empty never collide
	// a waiting byte also loads on the stop bit's closing tick, so frames run back to back
	assign xfer = tx_active && run && hold_full_r && !wr_txbuf
		&& (!tx_loaded_r || (bit_tick && tx_state_r == AST_STOP));
	assign bit_tick = samp_tick && tx_sub_r == AST_SUB_LAST;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			hold_r <= AST_RST_TX_BUFFER;
			hold_full_r <= 1'b0;
		end else if (wr_txbuf) begin
			hold_r <= reg_wdata_in;
			hold_full_r <= 1'b1;
		end else if (xfer) begin
			hold_full_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (srst_in)
			tx_empty_flag_r <= AST_RST_IRQ_FLAGS[AST_BIT_TX_EMPTY];
		else if (xfer || (wr_transmit_status_control && reg_wdata_in[AST_BIT_TX_EN] && !tx_en_r))
			tx_empty_flag_r <= 1'b1;
		else if (wr_txbuf)
			tx_empty_flag_r <= 1'b0;
	end

	always_ff @(posedge clk_sys_in) begin
		tx_oe_r <= !srst_in && tx_active;
		if (srst_in || !tx_active) begin
			tx_state_r <= AST_IDLE;
			tx_loaded_r <= 1'b0;
			tx_line_r <= 1'b1;
			tx_sub_r <= 4'd0;
			tx_bits_r <= 4'd0;
			tx_sh_r <= 9'h000;
			tx_nine_r <= 1'b0;
		end else if (run) begin
			if (samp_tick)
				tx_sub_r <= tx_sub_r + 4'd1;
			if (xfer) begin
				// ninth bit is taken now, hence written before the data
				tx_sh_r <= {tx_ninth_r, hold_r};
				tx_nine_r <= tx_nine_sel_r;
				tx_loaded_r <= 1'b1;
			end
			if (bit_tick) begin
				case (tx_state_r)
					AST_IDLE: if (tx_loaded_r) begin
						tx_line_r <= 1'b0;
						tx_state_r <= AST_START;
					end
					AST_START: begin
						tx_line_r <= tx_sh_r[0];
						tx_bits_r <= 4'd0;
						tx_state_r <= AST_DATA;
					end
					AST_DATA: if (tx_bits_r == (tx_nine_r ? AST_LAST_BIT_9 : AST_LAST_BIT_8)) begin
						tx_line_r <= 1'b1;
						tx_state_r <= AST_STOP;
					end else begin
						tx_sh_r <= {1'b0, tx_sh_r[8:1]};
						tx_line_r <= tx_sh_r[1];
						tx_bits_r <= tx_bits_r + 4'd1;
					end
					AST_STOP: if (xfer) begin
						tx_line_r <= 1'b0;
						tx_state_r <= AST_START;
					end else begin
						tx_loaded_r <= 1'b0;
						tx_state_r <= AST_IDLE;
					end
					default: tx_state_r <= AST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		link.dev_tx <= srst_in ? 1'b1 : tx_line_r;
		link.dev_tx_oe <= srst_in ? 1'b0 : tx_oe_r;
	end

	// receiver
	ast_frame_state_t rx_state_r;
	logic rx_run, rx_prev_r, vote_a_r, vote_b_r, maj, stop_dec, push, pop, rx_overrun_r;
	logic [3:0] rx_sub_r, rx_bits_r;
	logic [8:0] rx_sh_r;
	logic [9:0] entry;
	logic [1:0] count_r;
	logic wr_ptr_r, rd_ptr_r;
	logic [9:0] fifo_q [AST_RX_FIFO_DEPTH];

	assign rx_run = port_on && rx_cont_en_r;
	assign maj = (vote_a_r && vote_b_r) || (vote_a_r && link.rem_tx)
		|| (vote_b_r && link.rem_tx);
	assign stop_dec = rx_run && samp_tick && rx_state_r == AST_STOP && rx_sub_r == AST_SUB_VOTE_C;
	assign push = stop_dec && !rx_overrun_r && count_r != AST_RX_FIFO_DEPTH;
	assign pop = reg_rd_in && reg_addr_in == AST_ADDR_RX_PORT && count_r != 2'd0;
	// entry: framing error, ninth bit, data byte; no parity check made
	assign entry = rx_nine_sel_r ? {!maj, rx_sh_r} : {!maj, 1'b0, rx_sh_r[8:1]};

	always_ff @(posedge clk_sys_in) begin
		if (srst_in || !rx_run) begin
			rx_state_r <= AST_IDLE;
			rx_overrun_r <= 1'b0;
			rx_prev_r <= 1'b1;
			rx_sub_r <= 4'd0;
			rx_bits_r <= 4'd0;
			rx_sh_r <= 9'h000;
			vote_a_r <= 1'b1;
			vote_b_r <= 1'b1;
		end else if (run) begin
			rx_prev_r <= link.rem_tx;
			if (rx_state_r == AST_IDLE) begin
				rx_sub_r <= 4'd0;
				if (rx_prev_r && !link.rem_tx)
					rx_state_r <= AST_START;
			end else if (samp_tick) begin
				rx_sub_r <= rx_sub_r + 4'd1;
				if (rx_sub_r == AST_SUB_VOTE_A)
					vote_a_r <= link.rem_tx;
				if (rx_sub_r == AST_SUB_VOTE_B)
					vote_b_r <= link.rem_tx;
				if (rx_sub_r == AST_SUB_VOTE_C) begin
					case (rx_state_r)
						AST_START: if (maj) rx_state_r <= AST_IDLE;
						AST_DATA: rx_sh_r <= {maj, rx_sh_r[8:1]};
						AST_STOP: begin
							if (!rx_overrun_r && count_r == AST_RX_FIFO_DEPTH)
								rx_overrun_r <= 1'b1;
							rx_state_r <= AST_IDLE;
						end
						default: rx_state_r <= AST_IDLE;
					endcase
				end
				if (rx_sub_r == AST_SUB_LAST) begin
					rx_bits_r <= rx_bits_r + 4'd1;
					if (rx_state_r == AST_START) begin
						rx_bits_r <= 4'd0;
						rx_state_r <= AST_DATA;
					end else if (rx_state_r == AST_DATA && rx_bits_r ==
						(rx_nine_sel_r ? AST_LAST_BIT_9 : AST_LAST_BIT_8))
						rx_state_r <= AST_STOP;
				end
			end
		end
	end

	// fifo pointers; a pop and a push in one cycle leave the count alone
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			count_r <= 2'd0;
			wr_ptr_r <= 1'b0;
			rd_ptr_r <= 1'b0;
		end else begin
			if (push)
				wr_ptr_r <= !wr_ptr_r;
			if (pop)
				rd_ptr_r <= !rd_ptr_r;
			count_r <= count_r + {1'b0, push} - {1'b0, pop};
		end
	end

	for (genvar i = 0; i < AST_RX_FIFO_DEPTH; i++) begin : g_entry
		logic [9:0] ent_r;
		always_ff @(posedge clk_sys_in) begin
			if (srst_in)
				ent_r <= 10'h000;
			else if (push && wr_ptr_r == 1'(i))
				ent_r <= entry;
		end
		assign fifo_q[i] = ent_r;
	end

	// register reads, one cycle after the strobe
	logic [9:0] head;
	logic rx_avail;
	assign head = fifo_q[rd_ptr_r];
	assign rx_avail = count_r != 2'd0;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			reg_rdata_out <= 8'h00;
			irq_out <= 1'b0;
		end else begin
			irq_out <= (tx_empty_flag_r && irq_en_r[AST_BIT_TX_EMPTY])
				|| (rx_avail && irq_en_r[AST_BIT_RX_AVAIL]);
			reg_rdata_out <= 8'h00;
			if (reg_rd_in) begin
				case (reg_addr_in)
					AST_ADDR_IRQ_FLAGS: begin
						reg_rdata_out[AST_BIT_RX_AVAIL] <= rx_avail;
						reg_rdata_out[AST_BIT_TX_EMPTY] <= tx_empty_flag_r;
					end
					AST_ADDR_RX_STATUS: begin
						reg_rdata_out[AST_BIT_PORT_EN] <= port_en_r;
						reg_rdata_out[AST_BIT_RX_NINE_SEL] <= rx_nine_sel_r;
						reg_rdata_out[AST_BIT_RX_CONT_EN] <= rx_cont_en_r;
						reg_rdata_out[AST_BIT_RX_FRAME_ERR] <= head[9];
						reg_rdata_out[AST_BIT_RX_OVERRUN] <= rx_overrun_r;
						reg_rdata_out[AST_BIT_RX_NINTH] <= head[8];
					end
					AST_ADDR_TX_BUFFER: reg_rdata_out <= hold_r;
					AST_ADDR_RX_PORT: reg_rdata_out <= head[7:0];
					AST_ADDR_IRQ_EN: reg_rdata_out <= irq_en_r;
					AST_ADDR_TX_STATUS: begin
						reg_rdata_out[AST_BIT_CLK_SRC] <= clk_src_r;
						reg_rdata_out[AST_BIT_TX_NINE_SEL] <= tx_nine_sel_r;
						reg_rdata_out[AST_BIT_TX_EN] <= tx_en_r;
						reg_rdata_out[AST_BIT_SYNC_SEL] <= sync_sel_r;
						reg_rdata_out[AST_BIT_HIGH_SPEED] <= high_speed_r;
						reg_rdata_out[AST_BIT_TX_SH_EMPTY] <= !tx_loaded_r;
						reg_rdata_out[AST_BIT_TX_NINTH] <= tx_ninth_r;
					end
					AST_ADDR_BAUD_DIV: reg_rdata_out <= baud_div_r;
					default: ;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* logic/ast_serial_rem.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_serial_rem
	import ast_pkg::*;
#(
	parameter int BIT_CYCLES = 16
)(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// user side
	input wire logic nine_bit_in,
	input wire logic send_valid_in,
	input wire logic [8:0] send_data_in,
	output logic send_ready_out,
	output logic recv_valid_out,
	output logic [8:0] recv_data_out,
	output logic recv_rx_framing_err_out,
	// serial link
	ast_link_if.rem link
);
	localparam int CW = $clog2(BIT_CYCLES);
	localparam logic [CW-1:0] CNT_LAST = CW'(BIT_CYCLES - 1);
	localparam logic [CW-1:0] CNT_MID = CW'(BIT_CYCLES / 2);

	// fewer clocks per bit leave no room for a mid-bit sample
	if (BIT_CYCLES < 4) begin : g_bad_bit_cycles
		$error("BIT_CYCLES must be at least 4");
	end

	// transmit: frame of start, data lsb first, stop
	ast_frame_state_t ts_r;
	logic [CW-1:0] tc_r;
	logic [3:0] tb_r;
	logic [8:0] tsh_r;
	logic tnine_r;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ts_r <= AST_IDLE;
			tc_r <= '0;
			tb_r <= 4'd0;
			tsh_r <= 9'h000;
			tnine_r <= 1'b0;
			link.rem_tx <= 1'b1;
			send_ready_out <= 1'b1;
		end else if (ts_r == AST_IDLE) begin
			if (send_valid_in && send_ready_out) begin
				tsh_r <= send_data_in;
				tnine_r <= nine_bit_in;
				link.rem_tx <= 1'b0;
				send_ready_out <= 1'b0;
				tc_r <= '0;
				ts_r <= AST_START;
			end
		end else if (tc_r != CNT_LAST) begin
			tc_r <= tc_r + 1'b1;
		end else begin
			tc_r <= '0;
			case (ts_r)
				AST_START: begin
					link.rem_tx <= tsh_r[0];
					tb_r <= 4'd0;
					ts_r <= AST_DATA;
				end
				AST_DATA: if (tb_r == (tnine_r ? AST_LAST_BIT_9 : AST_LAST_BIT_8)) begin
					link.rem_tx <= 1'b1;
					ts_r <= AST_STOP;
				end else begin
					tsh_r <= {1'b0, tsh_r[8:1]};
					link.rem_tx <= tsh_r[1];
					tb_r <= tb_r + 4'd1;
				end
				default: begin
					send_ready_out <= 1'b1;
					ts_r <= AST_IDLE;
				end
			endcase
		end
	end

	// receive: mid-bit sampling of the device line
	ast_frame_state_t rs_r;
	logic [CW-1:0] rc_r;
	logic [3:0] rb_r;
	logic [8:0] rsh_r;
	logic rprev_r;

	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			rs_r <= AST_IDLE;
			rc_r <= '0;
			rb_r <= 4'd0;
			rsh_r <= 9'h000;
			rprev_r <= 1'b1;
			recv_valid_out <= 1'b0;
			recv_data_out <= 9'h000;
			recv_rx_framing_err_out <= 1'b0;
		end else begin
			rprev_r <= link.tx_line;
			recv_valid_out <= 1'b0;
			if (rs_r == AST_IDLE) begin
				rc_r <= '0;
				if (rprev_r && !link.tx_line)
					rs_r <= AST_START;
			end else begin
				rc_r <= (rc_r == CNT_LAST) ? '0 : rc_r + 1'b1;
				if (rc_r == CNT_MID) begin
					case (rs_r)
						AST_START: if (link.tx_line) rs_r <= AST_IDLE;
						AST_DATA: begin
							rsh_r <= {link.tx_line, rsh_r[8:1]};
							rb_r <= rb_r + 4'd1;
						end
						default: begin
							recv_valid_out <= 1'b1;
							recv_rx_framing_err_out <= !link.tx_line;
							recv_data_out <= nine_bit_in ? rsh_r : {1'b0, rsh_r[8:1]};
							rs_r <= AST_IDLE;
						end
					endcase
				end
				if (rc_r == CNT_LAST) begin
					if (rs_r == AST_START) begin
						rb_r <= 4'd0;
						rs_r <= AST_DATA;
					end else if (rs_r == AST_DATA
						&& rb_r == (nine_bit_in ? 4'd9 : 4'd8))
						rs_r <= AST_STOP;
				end
			end
		end
	end
endmodule
`default_nettype wire

/* test/ast_link_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_link_assertions #(
	parameter int BIT_CYCLES = 16
)(
	// clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// link signals
	input wire logic dev_tx,
	input wire logic dev_tx_oe,
	input wire logic rem_tx,
	input wire logic tx_line
);
	// run lengths saturate so long idles cannot wrap into a false bit count
	logic [11:0] tx_low_r;
	logic [11:0] tx_high_r;
	logic [11:0] rem_low_r;
	logic [11:0] rem_high_r;
	function automatic logic [11:0] sat_inc(input logic [11:0] v);
		return (v == 12'hFFF) ? v : v + 12'h001;
	endfunction
	always_ff @(posedge clk_sys_in) begin
		tx_low_r <= (srst_in || tx_line) ? 12'h000 : sat_inc(tx_low_r);
		tx_high_r <= (srst_in || !tx_line) ? 12'h000 : sat_inc(tx_high_r);
	end
	always_ff @(posedge clk_sys_in) begin
		rem_low_r <= (srst_in || rem_tx) ? 12'h000 : sat_inc(rem_low_r);
		rem_high_r <= (srst_in || !rem_tx) ? 12'h000 : sat_inc(rem_high_r);
	end
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (srst_in);
	property p_reset_idle;
		$past(srst_in) |-> dev_tx && !dev_tx_oe && rem_tx;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
	// an abort lifts the line mid bit in the same cycle that the pin is released
	property p_tx_low_run;
		$rose(tx_line) && dev_tx_oe |-> (tx_low_r % BIT_CYCLES == 0) or (##[1:2] !dev_tx_oe);
	endproperty
	a_tx_low_run: assert property (p_tx_low_run) else $error("tx low run not whole bits");
	property p_rem_low_run;
		$rose(rem_tx) |-> rem_low_r % BIT_CYCLES == 0;
	endproperty
	a_rem_low_run: assert property (p_rem_low_run) else $error("rem low run not whole bits");
	property p_tx_low_max;
		dev_tx_oe |-> tx_low_r <= 10 * BIT_CYCLES;
	endproperty
	a_tx_low_max: assert property (p_tx_low_max) else $error("tx stop bit missing");
	property p_rem_low_max;
		rem_low_r <= 10 * BIT_CYCLES;
	endproperty
	a_rem_low_max: assert property (p_rem_low_max) else $error("rem stop bit missing");
	property p_tx_gap;
		$fell(tx_line) |-> tx_high_r >= BIT_CYCLES;
	endproperty
	a_tx_gap: assert property (p_tx_gap) else $error("tx start without idle or stop");
	property p_rem_gap;
		$fell(rem_tx) |-> rem_high_r >= BIT_CYCLES;
	endproperty
	a_rem_gap: assert property (p_rem_gap) else $error("rem start without idle or stop");
	property p_tx_start_hold;
		$fell(tx_line) |-> (!tx_line) [*8];
	endproperty
	a_tx_start_hold: assert property (p_tx_start_hold) else $error("tx start bit cut short");
endmodule
`default_nettype wire

/* test/ast_serial_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_serial_tb
	import ast_pkg::*;
;
	localparam int BIT = 16;
	logic clk_sys_in, srst_in, sleep_in, sel_b, reg_wr, reg_rd, irq_a;
	logic nine_bit, send_valid, send_ready, recv_valid, recv_rx_framing_err;
	logic [7:0] reg_addr, reg_wdata, rdata_a, rdata_b;
	logic [8:0] send_data, recv_data;
	logic [7:0] rst_addr [7];
	logic [7:0] rst_val [7];
	int n_fail, tests_run;
	ast_link_if i_ast_link_if ();
	ast_link_if i_ast_link_if_b ();
	ast_serial_dev i_ast_serial_dev (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.sleep_in(sleep_in), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr & ~sel_b),
		.reg_rd_in(reg_rd & ~sel_b), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata_a),
		.irq_out(irq_a), .link(i_ast_link_if));
	// second device faces a bench driver that can break the frame on purpose
	ast_serial_dev i_ast_serial_dev_b (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
		.sleep_in(1'b0), .reg_addr_in(reg_addr), .reg_wr_in(reg_wr & sel_b),
		.reg_rd_in(reg_rd & sel_b), .reg_wdata_in(reg_wdata), .reg_rdata_out(rdata_b),
		.irq_out(), .link(i_ast_link_if_b));
	ast_serial_rem #(.BIT_CYCLES(BIT)) i_ast_serial_rem (.clk_sys_in(clk_sys_in),
		.srst_in(srst_in), .nine_bit_in(nine_bit), .send_valid_in(send_valid),
		.send_data_in(send_data), .send_ready_out(send_ready), .recv_valid_out(recv_valid),
		.recv_data_out(recv_data), .recv_rx_framing_err_out(recv_rx_framing_err), .link(i_ast_link_if));
	ast_link_assertions #(.BIT_CYCLES(BIT)) i_ast_link_assertions (.clk_sys_in(clk_sys_in),
		.srst_in(srst_in), .dev_tx(i_ast_link_if.dev_tx), .dev_tx_oe(i_ast_link_if.dev_tx_oe),
		.rem_tx(i_ast_link_if.rem_tx), .tx_line(i_ast_link_if.tx_line));
	initial begin
		clk_sys_in = 1'b0;
		forever #25 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic timeout(input string what);
		n_fail++;
		$display("CHECK FAILED %s expected done seen timeout", what);
		report_and_stop();
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge clk_sys_in);
		reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(negedge clk_sys_in);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge clk_sys_in);
		reg_rd = 1'b0;
		chk(what, {1'b0, exp}, {1'b0, sel_b ? rdata_b : rdata_a});
	endtask
	task automatic wait_recv(input logic [8:0] exp, input string what, output int n);
		@(negedge clk_sys_in);
		n = 1;
		while (recv_valid !== 1'b1) begin
			if (n++ > 400) timeout(what);
			@(negedge clk_sys_in);
		end
		chk(what, exp, recv_data);
		chk("remote stop", 9'h000, {8'h00, recv_rx_framing_err});
	endtask
	task automatic wait_ready();
		int i;
		i = 0;
		while (send_ready !== 1'b1) begin
			if (i++ > 400) timeout("remote ready");
			@(negedge clk_sys_in);
		end
	endtask
	task automatic rem_send(input logic [8:0] d);
		wait_ready();
		send_data = d;
		send_valid = 1'b1;
		@(negedge clk_sys_in);
		send_valid = 1'b0;
		@(negedge clk_sys_in);
		wait_ready();
	endtask
	task automatic wait_low();
		int i;
		i = 0;
		while (i_ast_link_if.tx_line !== 1'b0) begin
			if (i++ > 400) timeout("tx start");
			@(negedge clk_sys_in);
		end
	endtask
	task automatic cap_wire(input logic [8:0] exp, input int nb);
		logic [8:0] got;
		int i;
		got = 9'h000;
		wait_low();
		repeat (BIT / 2) @(negedge clk_sys_in);
		chk("start bit", 9'h000, {8'h00, i_ast_link_if.tx_line});
		for (i = 0; i < nb; i++) begin
			repeat (BIT) @(negedge clk_sys_in);
			got[i] = i_ast_link_if.tx_line;
		end
		repeat (BIT) @(negedge clk_sys_in);
		chk("wire data", exp, got);
		chk("stop bit", 9'h001, {8'h00, i_ast_link_if.tx_line});
	endtask
	task automatic drive_b(input logic [7:0] d, input logic stop_bit, input int bl);
		int i;
		int k;
		i_ast_link_if_b.rem_tx = 1'b0;
		repeat (bl) @(negedge clk_sys_in);
		for (i = 0; i < 8; i++) begin
			for (k = 0; k < bl; k++) begin
				// one-cycle spike at cycle 7 of each data bit, mid bit when bl is BIT: the vote must outweigh it
				i_ast_link_if_b.rem_tx = (k == 7) ? ~d[i] : d[i];
				@(negedge clk_sys_in);
			end
		end
		i_ast_link_if_b.rem_tx = stop_bit;
		repeat (bl) @(negedge clk_sys_in);
		i_ast_link_if_b.rem_tx = 1'b1;
		repeat (2 * bl) @(negedge clk_sys_in);
	endtask
	initial begin
		int n;
		{srst_in, sleep_in, sel_b, reg_wr, reg_rd, nine_bit, send_valid} = 7'h40;
		{reg_addr, reg_wdata, send_data} = 25'h0000000;
		i_ast_link_if_b.rem_tx = 1'b1;
		n_fail = 0;
		tests_run = 0;
		rst_addr = '{AST_ADDR_IRQ_FLAGS, AST_ADDR_RX_STATUS, AST_ADDR_TX_BUFFER,
			AST_ADDR_IRQ_EN, AST_ADDR_TX_STATUS, AST_ADDR_BAUD_DIV, 8'h5A};
		rst_val = '{AST_RST_IRQ_FLAGS, AST_RST_RX_STATUS, AST_RST_TX_BUFFER,
			AST_RST_IRQ_EN, AST_RST_TX_STATUS, AST_RST_BAUD_DIV, 8'h00};
		repeat (16) @(posedge clk_sys_in);
		@(negedge clk_sys_in);
		srst_in = 1'b0;
		wr(AST_ADDR_IRQ_FLAGS, 8'hFF);
		wr(8'h5A, 8'hFF);
		for (n = 0; n < 7; n++) begin
			rd(rst_addr[n], rst_val[n], "reset value");
		end
		wr(AST_ADDR_BAUD_DIV, 8'h00);
		wr(AST_ADDR_TX_STATUS, 8'h04);
		wr(AST_ADDR_RX_STATUS, 8'h90);
		rd(AST_ADDR_IRQ_FLAGS, 8'h00, "flags idle");
		wr(AST_ADDR_TX_STATUS, 8'h24);
		rd(AST_ADDR_IRQ_FLAGS, 8'h10, "flag on enable");
		rd(AST_ADDR_TX_STATUS, 8'h26, "shifter empty");
		wr(AST_ADDR_IRQ_EN, 8'h20);
		chk("irq masked", 9'h000, {8'h00, irq_a});
		fork
			begin
				wr(AST_ADDR_TX_BUFFER, 8'hA5);
				rd(AST_ADDR_IRQ_FLAGS, 8'h10, "moved at once");
				wr(AST_ADDR_TX_BUFFER, 8'h3C);
				rd(AST_ADDR_IRQ_FLAGS, 8'h00, "flag cleared");
				rd(AST_ADDR_TX_STATUS, 8'h24, "shifter busy");
			end
			cap_wire(9'h0A5, 8);
			begin
				wait_recv(9'h0A5, "first byte", n);
				wait_recv(9'h03C, "second byte", n);
				chk("frame spacing", 9'(10 * BIT), 9'(n));
			end
		join
		repeat (BIT) @(negedge clk_sys_in);
		rd(AST_ADDR_TX_STATUS, 8'h26, "shifter drained");
		nine_bit = 1'b1;
		wr(AST_ADDR_RX_STATUS, 8'hD0);
		wr(AST_ADDR_TX_STATUS, 8'h65);
		fork
			wr(AST_ADDR_TX_BUFFER, 8'h5A);
			cap_wire(9'h15A, 9);
			wait_recv(9'h15A, "nine bit frame", n);
		join
		rem_send(9'h1C3);
		rd(AST_ADDR_RX_STATUS, 8'hD1, "ninth bit in");
		rd(AST_ADDR_RX_PORT, 8'hC3, "nine bit data");
		nine_bit = 1'b0;
		wr(AST_ADDR_RX_STATUS, 8'h90);
		wr(AST_ADDR_TX_STATUS, 8'h24);
		rem_send(9'h011);
		rem_send(9'h022);
		rem_send(9'h033);
		chk("rx irq", 9'h001, {8'h00, irq_a});
		rd(AST_ADDR_IRQ_FLAGS, 8'h30, "data avail");
		rd(AST_ADDR_RX_STATUS, 8'h92, "overrun");
		rd(AST_ADDR_RX_PORT, 8'h11, "fifo head");
		rd(AST_ADDR_RX_PORT, 8'h22, "fifo second");
		rd(AST_ADDR_IRQ_FLAGS, 8'h10, "avail cleared");
		rem_send(9'h044);
		rd(AST_ADDR_IRQ_FLAGS, 8'h10, "blocked push");
		wr(AST_ADDR_RX_STATUS, 8'h80);
		rem_send(9'h055);
		rd(AST_ADDR_IRQ_FLAGS, 8'h10, "rx disabled");
		rd(AST_ADDR_RX_STATUS, 8'h80, "overrun gone");
		wr(AST_ADDR_RX_STATUS, 8'h90);
		rem_send(9'h066);
		rd(AST_ADDR_RX_PORT, 8'h66, "rx recovered");
		fork
			wr(AST_ADDR_TX_BUFFER, 8'h00);
			wait_low();
		join
		repeat (2 * BIT) @(negedge clk_sys_in);
		wr(AST_ADDR_TX_STATUS, 8'h04);
		repeat (2) @(negedge clk_sys_in);
		chk("pin released", 9'h000, {8'h00, i_ast_link_if.dev_tx_oe});
		rd(AST_ADDR_TX_STATUS, 8'h06, "tx reset");
		// the remote still closes the broken frame; let it finish first
		repeat (10 * BIT) @(negedge clk_sys_in);
		wr(AST_ADDR_TX_STATUS, 8'h24);
		sleep_in = 1'b1;
		wr(AST_ADDR_TX_BUFFER, 8'h96);
		for (n = 0; n < 4 * BIT; n++) begin
			@(negedge clk_sys_in);
			chk("sleep line", 9'h001, {8'h00, i_ast_link_if.tx_line});
		end
		sleep_in = 1'b0;
		wait_recv(9'h096, "after wake", n);
		sel_b = 1'b1;
		wr(AST_ADDR_BAUD_DIV, 8'h00);
		wr(AST_ADDR_TX_STATUS, 8'h04);
		wr(AST_ADDR_RX_STATUS, 8'h90);
		drive_b(8'hA3, 1'b0, BIT);
		rd(AST_ADDR_RX_STATUS, 8'h94, "framing error");
		rd(AST_ADDR_RX_PORT, 8'hA3, "framed byte");
		drive_b(8'h4E, 1'b1, BIT);
		rd(AST_ADDR_RX_STATUS, 8'h90, "clean stop");
		rd(AST_ADDR_RX_PORT, 8'h4E, "voted byte");
		wr(AST_ADDR_TX_STATUS, 8'h00);
		drive_b(8'hC5, 1'b1, 4 * BIT);
		rd(AST_ADDR_RX_PORT, 8'hC5, "x64 byte");
		wr(AST_ADDR_TX_STATUS, 8'h14);
		drive_b(8'h77, 1'b1, BIT);
		rd(AST_ADDR_IRQ_FLAGS, 8'h00, "sync mode off");
		report_and_stop();
	end
endmodule
`default_nettype wire
